// [logic/crtt_top.sv]
// What this block does
// - Any mailbox data frame sets shared data flag; remote frame sets remote flag.
// - Mailbox-zero interrupt comes from mailbox 0 remote or data pending bit.
// - Other-mailbox interrupt comes from pending bits of mailboxes 1 to 15.
// - Only the mailbox-zero interrupt may start the transfer engine.
// - Transmit and receive error counts at 96 or above set separate warning flags.
// - Error-passive on flag 5, bus-off entry or recovery on flag 6.
// - Message error on flag 13 only in test mode, never a trigger.
// - Flag 0 set on completed move into reset, halt or sleep.
// - Overload frame on flag 7, overrun on flag 9, both overrun interrupt.
// - In sleep mode, bus activity sets flag 1.
// - Transmit done or disabled sets flag 8, never a trigger.
// - Sixteen mailboxes, fifteen configurable, mailbox zero receive only.
// - Each request loads descriptor unless read skip reuses the held one, transfers, then writes descriptor back.
// - Vector entry of the source gives descriptor address, then descriptor read.
// - Descriptor address low two bits forced to zero.
// - Source and destination addresses step per mode fields independently.
// - Primary count decrements by one per transfer.
// - Updated address and count fields stored back to descriptor.
// - Normal, repeat and block modes; byte, word and long word sizes.
// - Chain bit makes one request process several descriptors.
// - CPU interrupt after every transfer, or at end of count in normal and block modes only.
// - Descriptor read skip option and short address mode supported.
// - In block mode, block count decrements once per whole block.
`default_nettype none
module crtt_top
  import crtt_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic [NMB-1:0]   DATA_FRAME_RX_STB,
  input  wire logic [NMB-1:0]   REMOTE_FRAME_RX_STB,
  input  wire logic [NMB-1:0]   MB_PEND_CLR,
  input  wire logic [NFLAG-1:0] FLAG_CLR,
  input  wire logic             TX_DONE_STB,
  input  wire logic [7:0]       TEC,
  input  wire logic [7:0]       REC,
  input  wire logic             ERR_PASSIVE_STB,
  input  wire logic             BUSOFF_STB,
  input  wire logic             MSG_ERR_STB,
  input  wire logic             TEST_MODE,
  input  wire logic             STATE_ENTERED_STB,
  input  wire logic             OVERLOAD_STB,
  input  wire logic             OVERRUN_STB,
  input  wire logic             SLEEP_MODE,
  input  wire logic             BUS_ACTIVITY,
  input  wire logic             TRIG_ENABLE_SET,
  input  wire logic [AW-1:0]    VECTOR_ADDR,
  input  wire logic             READ_SKIP,
  input  wire logic             SHORT_ADDR,
  output logic [NFLAG-1:0]      INTERRUPT_FLAG_BITS,
  output logic [NMB-1:0]        DATA_FRAME_PENDING_BITS,
  output logic [NMB-1:0]        REMOTE_FRAME_PENDING_BITS,
  output logic                  MAILBOX_ZERO_RX_IRQ,
  output logic                  OTHER_MAILBOX_RX_IRQ,
  output logic                  ERROR_STATE_IRQ,
  output logic                  OVERRUN_GROUP_IRQ,
  output logic                  TRANSMIT_DONE_IRQ,
  output logic                  TRIG_ENABLE,
  output logic                  ENGINE_BUSY,
  output logic                  CPU_IRQ,
  output logic                  BUS_REQ,
  output logic                  BUS_WE,
  output logic [AW-1:0]         BUS_ADDR,
  output logic [DW-1:0]         BUS_WDATA,
  output logic [1:0]            BUS_SIZE,
  input  wire logic             BUS_ACK,
  input  wire logic [DW-1:0]    BUS_RDATA
);
  typedef struct packed {
    logic [NFLAG-1:0] flg;
    logic [NMB-1:0]   dpend;
    logic [NMB-1:0]   rpend;
    logic             act_s1;
    logic             act_s2;
    logic             en;
    logic             irq;
    crtt_st_t         st;
    logic [AW-1:0]    dptr;
    logic [7:0]       ma;
    logic [7:0]       mb;
    logic [AW-1:0]    src;
    logic [AW-1:0]    dst;
    logic [15:0]      primary_count_field;
    logic [15:0]      block_count_field;
    logic [DW-1:0]    data;
    logic             loaded;
    logic             fwd;
  } crtt_state_t;

  crtt_state_t s_r, s_nxt;
  logic        act_in;
  logic [AW-1:0] step;
  logic [7:0]  blksz;
  logic        blk_end;
  logic        cnt_end;

  function automatic logic [AW-1:0] stepped(input logic [AW-1:0] a, input logic [1:0] m,
                                             input logic [AW-1:0] d);
    if (m == STEP_INC) stepped = a + d;
    else if (m == STEP_DEC) stepped = a - d;
    else stepped = a;
  endfunction

  always_comb begin
    s_nxt  = s_r;
    // Mailbox zero pending only; the other sources are never wired in
    act_in = s_r.dpend[0] | s_r.rpend[0];
    // Pending kept for the CPU must not restart the engine until it is cleared
    if (!act_in) s_nxt.fwd = 1'b0;
    case (s_r.ma[MA_SZ +: 2])
      SZ_BYTE: step = 32'h0000_0001;
      SZ_WORD: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
    blksz   = s_r.primary_count_field[15:8];
    blk_end = (s_r.ma[MA_MD +: 2] == MD_BLOCK) ? (s_r.primary_count_field[7:0] == 8'h01) : 1'b1;
    cnt_end = (s_r.ma[MA_MD +: 2] == MD_BLOCK) ? (s_r.block_count_field == 16'h0001)
            : (s_r.primary_count_field == 16'h0001);
    for (int i = 0; i < NMB; i++) begin
      // Set wins over clear
      s_nxt.dpend[i] = DATA_FRAME_RX_STB[i] | (s_r.dpend[i] & ~MB_PEND_CLR[i]);
      s_nxt.rpend[i] = REMOTE_FRAME_RX_STB[i] | (s_r.rpend[i] & ~MB_PEND_CLR[i]);
    end
    s_nxt.flg = s_r.flg & ~FLAG_CLR;
    if (|DATA_FRAME_RX_STB) s_nxt.flg[FL_DATA_RX] = 1'b1;
    if (|REMOTE_FRAME_RX_STB) s_nxt.flg[FL_REMOTE_RX] = 1'b1;
    if (TEC >= ERR_WARN_LVL) s_nxt.flg[FL_TEC_WARN] = 1'b1;
    if (REC >= ERR_WARN_LVL) s_nxt.flg[FL_REC_WARN] = 1'b1;
    if (ERR_PASSIVE_STB) s_nxt.flg[FL_PASSIVE] = 1'b1;
    if (BUSOFF_STB) s_nxt.flg[FL_BUSOFF] = 1'b1;
    if (MSG_ERR_STB && TEST_MODE) s_nxt.flg[FL_MSG_ERR] = 1'b1;
    if (STATE_ENTERED_STB) s_nxt.flg[FL_STATE] = 1'b1;
    if (OVERLOAD_STB) s_nxt.flg[FL_OVERLOAD] = 1'b1;
    if (OVERRUN_STB) s_nxt.flg[FL_OVERRUN] = 1'b1;
    if (SLEEP_MODE && s_r.act_s2) s_nxt.flg[FL_DATA_RX] = 1'b1;
    if (TX_DONE_STB) s_nxt.flg[FL_TX_DONE] = 1'b1;
    s_nxt.act_s1 = BUS_ACTIVITY;
    s_nxt.act_s2 = s_r.act_s1;
    s_nxt.irq    = 1'b0;
    if (TRIG_ENABLE_SET) s_nxt.en = 1'b1;
    case (s_r.st)
      S_IDLE: begin
        if (act_in && s_r.en && !s_r.fwd) s_nxt.st = S_VEC;
      end
      S_VEC: if (BUS_ACK) begin
        s_nxt.dptr = BUS_RDATA & ALIGN_MASK;
        s_nxt.st   = (READ_SKIP && s_r.loaded) ? S_RD : S_MODE;
      end
      S_MODE: if (BUS_ACK) begin
        s_nxt.ma = BUS_RDATA[15:8];
        s_nxt.mb = BUS_RDATA[7:0];
        s_nxt.st = S_SRC;
      end
      S_SRC: if (BUS_ACK) begin
        s_nxt.src = SHORT_ADDR ? (BUS_RDATA & SHORT_MASK) : BUS_RDATA;
        s_nxt.st  = S_DST;
      end
      S_DST: if (BUS_ACK) begin
        s_nxt.dst = SHORT_ADDR ? (BUS_RDATA & SHORT_MASK) : BUS_RDATA;
        s_nxt.st  = S_CNT;
      end
      S_CNT: if (BUS_ACK) begin
        s_nxt.primary_count_field    = BUS_RDATA[31:16];
        s_nxt.block_count_field    = BUS_RDATA[15:0];
        s_nxt.loaded = 1'b1;
        s_nxt.st     = S_RD;
      end
      S_RD: if (BUS_ACK) begin
        s_nxt.data = BUS_RDATA;
        s_nxt.st   = S_WR;
      end
      S_WR: if (BUS_ACK) begin
        s_nxt.src = stepped(s_r.src, s_r.ma[MA_SM +: 2], step);
        s_nxt.dst = stepped(s_r.dst, s_r.mb[MB_DM +: 2], step);
        if (s_r.ma[MA_MD +: 2] == MD_BLOCK) begin
          if (blk_end) begin
            s_nxt.primary_count_field = {blksz, blksz};
            s_nxt.block_count_field = s_r.block_count_field - 16'h0001;
            // Block area is rewound after each block
            if (s_r.mb[MB_DTS]) s_nxt.src = s_r.src - {24'h0, blksz - 8'h01} * step;
            else s_nxt.dst = s_r.dst - {24'h0, blksz - 8'h01} * step;
            s_nxt.st = S_WB_S;
          end else begin
            s_nxt.primary_count_field = {s_r.primary_count_field[15:8], s_r.primary_count_field[7:0] - 8'h01};
          end
        end else begin
          s_nxt.primary_count_field = s_r.primary_count_field - 16'h0001;
          if (s_r.ma[MA_MD +: 2] == MD_REPEAT && cnt_end) s_nxt.primary_count_field = s_r.block_count_field;
          s_nxt.st  = S_WB_S;
        end
        if (!(s_r.ma[MA_MD +: 2] == MD_BLOCK && !blk_end)) s_nxt.st = S_WB_S;
        else s_nxt.st = S_RD;
      end
      S_WB_S: if (BUS_ACK) s_nxt.st = S_WB_D;
      S_WB_D: if (BUS_ACK) s_nxt.st = S_WB_C;
      S_WB_C: if (BUS_ACK) s_nxt.st = S_NEXT;
      S_NEXT: begin
        if (s_r.mb[MB_CHN]) begin
          s_nxt.dptr = s_r.dptr + OFS_CNT + 32'h0000_0004;
          s_nxt.st   = S_MODE;
        end else s_nxt.st = S_DONE;
      end
      S_DONE: begin
        if (s_r.mb[MB_DIS] || (s_r.ma[MA_MD +: 2] != MD_REPEAT &&
            (s_r.ma[MA_MD +: 2] == MD_BLOCK ? s_r.block_count_field == 16'h0000 : s_r.primary_count_field == 16'h0000))) begin
          s_nxt.irq = 1'b1;
          s_nxt.fwd = 1'b1;
          if (!s_r.mb[MB_DIS]) s_nxt.en = TRIG_ENABLE_SET;
        end else begin
          // CPU sees nothing; the trigger condition is consumed here
          s_nxt.dpend[0] = DATA_FRAME_RX_STB[0];
          s_nxt.rpend[0] = REMOTE_FRAME_RX_STB[0];
        end
        s_nxt.st = S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_r <= '{st: S_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    BUS_REQ   = 1'b1;
    BUS_WE    = 1'b0;
    BUS_ADDR  = s_r.dptr;
    BUS_WDATA = s_r.data;
    BUS_SIZE  = 2'h2;
    case (s_r.st)
      S_VEC:  BUS_ADDR = VECTOR_ADDR;
      S_MODE: BUS_ADDR = s_r.dptr + OFS_MODE;
      S_SRC:  BUS_ADDR = s_r.dptr + (SHORT_ADDR ? OFS_SHORT_S : OFS_SRC);
      S_DST:  BUS_ADDR = s_r.dptr + (SHORT_ADDR ? OFS_SHORT_D : OFS_DST);
      S_CNT:  BUS_ADDR = s_r.dptr + OFS_CNT;
      S_RD: begin
        BUS_ADDR = s_r.src;
        BUS_SIZE = s_r.ma[MA_SZ +: 2];
      end
      S_WR: begin
        BUS_ADDR = s_r.dst;
        BUS_WE   = 1'b1;
        BUS_SIZE = s_r.ma[MA_SZ +: 2];
      end
      S_WB_S: begin
        BUS_ADDR = s_r.dptr + OFS_SRC;
        BUS_WE   = 1'b1;
        BUS_WDATA = s_r.src;
      end
      S_WB_D: begin
        BUS_ADDR = s_r.dptr + OFS_DST;
        BUS_WE   = 1'b1;
        BUS_WDATA = s_r.dst;
      end
      S_WB_C: begin
        BUS_ADDR = s_r.dptr + OFS_CNT;
        BUS_WE   = 1'b1;
        BUS_WDATA = {s_r.primary_count_field, s_r.block_count_field};
      end
      default: BUS_REQ = 1'b0;
    endcase
  end

  // Mailbox 0 is fixed receive-only; the other fifteen are set by the controller
  assign INTERRUPT_FLAG_BITS       = s_r.flg;
  assign DATA_FRAME_PENDING_BITS   = s_r.dpend;
  assign REMOTE_FRAME_PENDING_BITS = s_r.rpend;
  assign MAILBOX_ZERO_RX_IRQ  = s_r.dpend[0] | s_r.rpend[0];
  assign OTHER_MAILBOX_RX_IRQ = |(s_r.dpend[NMB-1:1] | s_r.rpend[NMB-1:1]);
  assign ERROR_STATE_IRQ = s_r.flg[FL_TEC_WARN] | s_r.flg[FL_REC_WARN] | s_r.flg[FL_PASSIVE]
                         | s_r.flg[FL_BUSOFF] | s_r.flg[FL_MSG_ERR] | s_r.flg[FL_STATE];
  assign OVERRUN_GROUP_IRQ = s_r.flg[FL_OVERLOAD] | s_r.flg[FL_OVERRUN] | s_r.flg[FL_DATA_RX]
                           & SLEEP_MODE;
  assign TRANSMIT_DONE_IRQ = s_r.flg[FL_TX_DONE];
  assign TRIG_ENABLE = s_r.en;
  assign ENGINE_BUSY = (s_r.st != S_IDLE);
  assign CPU_IRQ     = s_r.irq;

  property p_warn;
    @(posedge MCLK) disable iff (RST) (TEC >= ERR_WARN_LVL) |=> s_r.flg[FL_TEC_WARN];
  endproperty
  a_warn: assert property (p_warn) else $error("tec warn missing");
  property p_mz;
    @(posedge MCLK) disable iff (RST) $rose(DATA_FRAME_RX_STB[0]) |=> MAILBOX_ZERO_RX_IRQ;
  endproperty
  a_mz: assert property (p_mz) else $error("mb0 irq missing");
  property p_msg;
    @(posedge MCLK) disable iff (RST)
      (MSG_ERR_STB && !TEST_MODE && !s_r.flg[FL_MSG_ERR] && !FLAG_CLR[FL_MSG_ERR])
      |=> !s_r.flg[FL_MSG_ERR];
  endproperty
  a_msg: assert property (p_msg) else $error("msg err outside test");
  property p_start;
    @(posedge MCLK) disable iff (RST) (s_r.st == S_IDLE && !TRIG_ENABLE) |=> !ENGINE_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("start while disabled");
  property p_remote;
    @(posedge MCLK) disable iff (RST) (|REMOTE_FRAME_RX_STB) |=> s_r.flg[FL_REMOTE_RX];
  endproperty
  a_remote: assert property (p_remote) else $error("remote flag missing");
  property p_ovr;
    @(posedge MCLK) disable iff (RST) OVERRUN_STB |=> OVERRUN_GROUP_IRQ;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun irq missing");
  property p_dis;
    @(posedge MCLK) disable iff (RST) (s_r.st == S_DONE && s_r.mb[MB_DIS]) |=> CPU_IRQ;
  endproperty
  a_dis: assert property (p_dis) else $error("per transfer irq missing");
  property p_keep;
    @(posedge MCLK) disable iff (RST)
      (s_r.st == S_DONE && MAILBOX_ZERO_RX_IRQ && !MB_PEND_CLR[0] && !DATA_FRAME_RX_STB[0]
       && !REMOTE_FRAME_RX_STB[0]) |=> (MAILBOX_ZERO_RX_IRQ == CPU_IRQ);
  endproperty
  a_keep: assert property (p_keep) else $error("mb0 pending not handed over");
  property p_align;
    @(posedge MCLK) disable iff (RST) (s_r.st == S_MODE) |-> (BUS_ADDR[1:0] == 2'h0);
  endproperty
  a_align: assert property (p_align) else $error("descriptor unaligned");
  property p_trig;
    @(posedge MCLK) disable iff (RST)
      (s_r.st == S_IDLE && $past(s_r.st) == S_IDLE) ##1 (s_r.st == S_VEC)
      |-> $past(MAILBOX_ZERO_RX_IRQ);
  endproperty
  a_trig: assert property (p_trig) else $error("start without mb0");
  property p_cnt;
    @(posedge MCLK) disable iff (RST)
      (s_r.st == S_WR && BUS_ACK && s_r.ma[MA_MD +: 2] == MD_NORMAL)
      |=> (s_r.primary_count_field == $past(s_r.primary_count_field) - 16'h0001);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count not decremented");
  property p_wb;
    @(posedge MCLK) disable iff (RST) (s_r.st == S_WB_S) |-> (BUS_WE && BUS_REQ);
  endproperty
  a_wb: assert property (p_wb) else $error("write back missing");
  c_xfer: cover property (@(posedge MCLK) disable iff (RST) s_r.st == S_WB_C && BUS_ACK);
  c_irq:  cover property (@(posedge MCLK) disable iff (RST) CPU_IRQ);
  c_chain: cover property (@(posedge MCLK) disable iff (RST) s_r.st == S_NEXT && s_r.mb[MB_CHN]);
  c_block: cover property (@(posedge MCLK) disable iff (RST)
    s_r.st == S_WR && BUS_ACK && s_r.ma[MA_MD +: 2] == MD_BLOCK && blk_end);
  c_skip: cover property (@(posedge MCLK) disable iff (RST)
    s_r.st == S_VEC && BUS_ACK && READ_SKIP && s_r.loaded);
endmodule
`default_nettype wire

// [logic/crtt_pkg.sv]
`default_nettype none
package crtt_pkg;
  localparam int unsigned AW            = 32;
  localparam int unsigned DW            = 32;
  localparam int unsigned NMB           = 16;
  localparam int unsigned NFLAG         = 16;
  localparam logic [7:0]  ERR_WARN_LVL  = 8'h60;
  // Interrupt flag bit positions
  localparam int unsigned FL_STATE      = 0;
  localparam int unsigned FL_DATA_RX    = 1;
  localparam int unsigned FL_REMOTE_RX  = 2;
  localparam int unsigned FL_TEC_WARN   = 3;
  localparam int unsigned FL_REC_WARN   = 4;
  localparam int unsigned FL_PASSIVE    = 5;
  localparam int unsigned FL_BUSOFF     = 6;
  localparam int unsigned FL_OVERLOAD   = 7;
  localparam int unsigned FL_TX_DONE    = 8;
  localparam int unsigned FL_OVERRUN    = 9;
  localparam int unsigned FL_MSG_ERR    = 13;
  // Descriptor word offsets (bytes)
  localparam logic [AW-1:0] OFS_MODE    = 32'h0000_0000;
  localparam logic [AW-1:0] OFS_SRC     = 32'h0000_0004;
  localparam logic [AW-1:0] OFS_DST     = 32'h0000_0008;
  localparam logic [AW-1:0] OFS_CNT     = 32'h0000_000c;
  localparam logic [AW-1:0] OFS_SHORT_S = 32'h0000_0004;
  localparam logic [AW-1:0] OFS_SHORT_D = 32'h0000_0008;
  localparam logic [AW-1:0] ALIGN_MASK  = 32'hffff_fffc;
  localparam logic [AW-1:0] SHORT_MASK  = 32'h00ff_ffff;
  // Mode field a: [7:6] transfer mode, [5:4] size, [3:2] source step
  // Mode field b: [7] chain, [6] irq per transfer, [4] block on source, [3:2] dest step
  localparam int unsigned MA_MD  = 6;
  localparam int unsigned MA_SZ  = 4;
  localparam int unsigned MA_SM  = 2;
  localparam int unsigned MB_CHN = 7;
  localparam int unsigned MB_DIS = 6;
  localparam int unsigned MB_DTS = 4;
  localparam int unsigned MB_DM  = 2;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK  = 2'h2;
  localparam logic [1:0] STEP_INC  = 2'h2;
  localparam logic [1:0] STEP_DEC  = 2'h3;
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_WORD   = 2'h1;
  typedef enum logic [3:0] {
    S_IDLE, S_VEC, S_MODE, S_SRC, S_DST, S_CNT, S_RD, S_WR, S_WB_S, S_WB_D,
    S_WB_C, S_NEXT, S_DONE
  } crtt_st_t;
endpackage
`default_nettype wire

// [tb/crtt_mem.sv]
`default_nettype none
module crtt_mem
  import crtt_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          req,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               ack,
  output logic [DW-1:0]      rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DW-1:0] mem [0:255];
  logic [1:0]    wait_cnt;
  int            mseed = 32'h3c5;
  // Whole-word writes only: narrow writes clobber the other lanes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack      <= 1'b0;
      rdata    <= 32'h0;
      wait_cnt <= 2'h0;
    end else if (!ack && req && wait_cnt == 2'h0) begin
      ack      <= 1'b1;
      rdata    <= mem[addr[9:2]];
      wait_cnt <= 2'($random(mseed));
      if (we) begin
        mem[addr[9:2]] <= wdata;
      end
    end else begin
      ack   <= 1'b0;
      // Stale data never looks valid
      rdata <= ~rdata;
      if (req && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb
  import crtt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk = 1'b0, rst = 1'b1;
  logic [NMB-1:0]    dstb = 16'h0, rstb = 16'h0, pclr = 16'h0, fclr = 16'h0, dpend, rpend;
  logic [6:0]        ev = 7'h0;
  logic [7:0]        tec = 8'h0, rec = 8'h0, v, w;
  logic              tmode = 1'b0, sleep = 1'b0, act = 1'b0, tset = 1'b0;
  logic              rskip = 1'b0, sadr = 1'b0;
  logic [1:0]        sz_q [$];
  logic [NFLAG-1:0]  flags;
  logic              irq0, irq1, ers, ovr, txd, ten, busy, cpu, breq, bwe, back;
  logic [AW-1:0]     baddr;
  logic [AW-1:0]     adr_q [$];
  logic [DW-1:0]     bwd, brd, s0, s1;
  logic [1:0]        bsz;
  int                mismatches = 0, tests_run = 0, seed, i, n;
  int unsigned       fl [7] = '{FL_TX_DONE, FL_PASSIVE, FL_BUSOFF, FL_MSG_ERR, FL_STATE,
                                FL_OVERLOAD, FL_OVERRUN};
  logic [2:0]        grp [7] = '{3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1};

  crtt_top crtt_top_inst (
    .MCLK(mclk), .RST(rst), .DATA_FRAME_RX_STB(dstb), .REMOTE_FRAME_RX_STB(rstb),
    .MB_PEND_CLR(pclr), .FLAG_CLR(fclr), .TX_DONE_STB(ev[0]), .TEC(tec), .REC(rec),
    .ERR_PASSIVE_STB(ev[1]), .BUSOFF_STB(ev[2]), .MSG_ERR_STB(ev[3]), .TEST_MODE(tmode),
    .STATE_ENTERED_STB(ev[4]), .OVERLOAD_STB(ev[5]), .OVERRUN_STB(ev[6]),
    .SLEEP_MODE(sleep), .BUS_ACTIVITY(act), .TRIG_ENABLE_SET(tset),
    .VECTOR_ADDR(32'h0000_0100), .READ_SKIP(rskip), .SHORT_ADDR(sadr),
    .INTERRUPT_FLAG_BITS(flags), .DATA_FRAME_PENDING_BITS(dpend),
    .REMOTE_FRAME_PENDING_BITS(rpend), .MAILBOX_ZERO_RX_IRQ(irq0),
    .OTHER_MAILBOX_RX_IRQ(irq1), .ERROR_STATE_IRQ(ers), .OVERRUN_GROUP_IRQ(ovr),
    .TRANSMIT_DONE_IRQ(txd), .TRIG_ENABLE(ten), .ENGINE_BUSY(busy), .CPU_IRQ(cpu),
    .BUS_REQ(breq), .BUS_WE(bwe), .BUS_ADDR(baddr), .BUS_WDATA(bwd), .BUS_SIZE(bsz),
    .BUS_ACK(back), .BUS_RDATA(brd));

  crtt_mem crtt_mem_inst (
    .clk(mclk), .rst(rst), .req(breq), .we(bwe), .addr(baddr), .wdata(bwd),
    .ack(back), .rdata(brd));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [AW-1:0] stepped(logic [AW-1:0] a, logic [1:0] st, int unsigned b);
    return (st == STEP_INC) ? a + b : (st == STEP_DEC) ? a - b : a;
  endfunction

  // Two cycles of clear so a pipelined level cannot re-set a flag
  task automatic clr;
    @(posedge mclk);
    fclr <= 16'hffff;
    pclr <= 16'hffff;
    repeat (2) @(posedge mclk);
    fclr <= 16'h0;
    pclr <= 16'h0;
  endtask

  task automatic pulse_tset;
    @(posedge mclk);
    tset <= 1'b1;
    @(posedge mclk);
    tset <= 1'b0;
  endtask

  task automatic desc(input logic [7:0] ma, input logic [7:0] mb, input logic [31:0] cnt);
    crtt_mem_inst.mem[8'h40] = 32'h0000_0083;
    crtt_mem_inst.mem[8'h20] = {16'h0, ma, mb};
    crtt_mem_inst.mem[8'h21] = 32'h0000_0200;
    crtt_mem_inst.mem[8'h22] = 32'h0000_0300;
    crtt_mem_inst.mem[8'h23] = cnt;
  endtask

  task automatic trig(output int nirq);
    int k, idle;
    logic seen;
    nirq = 0;
    idle = 0;
    seen = 1'b0;
    adr_q.delete();
    sz_q.delete();
    @(posedge mclk);
    dstb[0] <= 1'b1;
    @(posedge mclk);
    dstb[0] <= 1'b0;
    for (k = 0; k < 600 && !(seen && idle > 3); k++) begin
      @(negedge mclk);
      if (cpu === 1'b1) nirq++;
      if (breq === 1'b1 && back === 1'b1) begin
        adr_q.push_back(baddr);
        sz_q.push_back(bsz);
      end
      if (busy === 1'b1) seen = 1'b1;
      else if (seen) idle++;
    end
    if (!(seen && idle > 3)) begin
      mismatches++;
      $display("[ERR] %0t engine never finished", $time);
      test_done();
    end
  endtask

  initial begin
    seed = 32'haf10;
    for (i = 0; i < 256; i++) crtt_mem_inst.mem[i] = $random(seed);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({flags, breq, ten}, 18'h0)
    @(posedge mclk);
    dstb <= 16'h0020;
    rstb <= 16'h0008;
    @(posedge mclk);
    dstb <= 16'h0;
    rstb <= 16'h0;
    @(negedge mclk);
    `CHK({dpend, rpend}, 32'h0020_0008)
    `CHK({flags[FL_DATA_RX], flags[FL_REMOTE_RX]}, 2'h3)
    `CHK({irq1, irq0}, 2'h2)
    pulse_tset();
    repeat (5) @(negedge mclk) `CHK(busy, 1'b0)
    clr();
    tmode <= 1'b1;
    for (i = 0; i < 7; i++) begin
      @(posedge mclk);
      ev <= 7'h1 << i;
      @(posedge mclk);
      ev <= 7'h0;
      @(negedge mclk);
      `CHK({flags[fl[i]], txd, ers, ovr}, {1'b1, grp[i]})
      clr();
    end
    tmode <= 1'b0;
    ev <= 7'h8;
    @(posedge mclk);
    ev <= 7'h0;
    @(negedge mclk);
    `CHK(flags[FL_MSG_ERR], 1'b0)
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h5f : (i == 1) ? 8'h60 : 8'($random(seed));
      w = (i == 0) ? 8'h60 : (i == 1) ? 8'h5f : 8'($random(seed));
      @(posedge mclk);
      tec <= v;
      rec <= w;
      repeat (3) @(negedge mclk);
      `CHK({flags[FL_TEC_WARN], flags[FL_REC_WARN]}, {v >= 8'h60, w >= 8'h60})
      @(posedge mclk);
      tec <= 8'h0;
      rec <= 8'h0;
      clr();
    end
    @(posedge mclk);
    act <= 1'b1;
    repeat (5) @(negedge mclk);
    `CHK(flags[FL_DATA_RX], 1'b0)
    @(posedge mclk);
    sleep <= 1'b1;
    repeat (5) @(negedge mclk);
    `CHK({flags[FL_DATA_RX], ovr}, 2'h3)
    @(posedge mclk);
    act <= 1'b0;
    sleep <= 1'b0;
    clr();
    // Normal, long word, source up, destination down, two transfers
    desc(8'h28, 8'h0c, 32'h0002_0000);
    s0 = crtt_mem_inst.mem[8'h80];
    s1 = crtt_mem_inst.mem[8'h81];
    pulse_tset();
    trig(n);
    `CHK(adr_q[0], 32'h0000_0100)
    `CHK(adr_q[1], 32'h0000_0080)
    `CHK(crtt_mem_inst.mem[8'hc0], s0)
    `CHK(crtt_mem_inst.mem[8'h21], stepped(32'h200, STEP_INC, 4))
    `CHK(crtt_mem_inst.mem[8'h22], stepped(32'h300, STEP_DEC, 4))
    `CHK(crtt_mem_inst.mem[8'h23][31:16], 16'h0001)
    `CHK({n[0], dpend[0], ten}, 3'h1)
    trig(n);
    `CHK(crtt_mem_inst.mem[8'hbf], s1)
    `CHK(crtt_mem_inst.mem[8'h23][31:16], 16'h0000)
    `CHK({n, dpend[0], ten}, {32'd1, 2'h2})
    clr();
    @(posedge mclk);
    rstb[0] <= 1'b1;
    @(posedge mclk);
    rstb[0] <= 1'b0;
    repeat (10) @(negedge mclk) `CHK(breq, 1'b0)
    `CHK({rpend[0], irq0, ten}, 3'h6)
    clr();
    // Block of three words, source is block area, interrupt per transfer
    desc(8'h98, 8'h58, 32'h0303_0002);
    pulse_tset();
    trig(n);
    `CHK(crtt_mem_inst.mem[8'h21], 32'h0000_0200)
    `CHK(crtt_mem_inst.mem[8'h22], stepped(32'h300, STEP_INC, 6))
    `CHK(crtt_mem_inst.mem[8'h23], 32'h0303_0001)
    `CHK({n, dpend[0], ten}, {32'd1, 2'h3})
    `CHK({adr_q[5], sz_q[5], sz_q[0]}, {32'h0000_0200, SZ_WORD, 2'h2})
    clr();
    // Short addresses drop the upper byte of the fetched source
    desc(8'h98, 8'h58, 32'h0303_0002);
    crtt_mem_inst.mem[8'h21] = 32'hff00_0200;
    sadr <= 1'b1;
    trig(n);
    `CHK(crtt_mem_inst.mem[8'h21], 32'h0000_0200)
    clr();
    // Read skip runs from the held descriptor; the memory copy is poisoned
    sadr <= 1'b0;
    rskip <= 1'b1;
    crtt_mem_inst.mem[8'h22] = 32'h0;
    trig(n);
    `CHK(adr_q[1], 32'h0000_0200)
    `CHK(crtt_mem_inst.mem[8'h22], stepped(32'h306, STEP_INC, 6))
    `CHK({crtt_mem_inst.mem[8'h23], n}, {32'h0303_0000, 32'd1})
    test_done();
  end
endmodule
`default_nettype wire
